// [verilog/sdrct_pkg.sv]
// Purpose: shared constants, types and register map of the sdram core
// Assumes: one clock, pins sampled on its rising edge
// Notes:   storage is a small flop window, not the full array

// ==========================================================
// package
package sdrct_pkg;

	// ==========================================================
	// geometry
	localparam int DATA_W    = 16;
	localparam int ADDR_W    = 12;
	localparam int COL_W     = 8;
	localparam int NBANK     = 4;
	localparam int LANES     = 2;
	localparam int MEM_ROW_W = 2;
	localparam int MEM_COL_W = 4;
	localparam int MEM_IDX_W = 8;
	localparam int MEM_DEPTH = 256;
	localparam int APB_AW    = 8;

	// ==========================================================
	// mode register fields
	localparam int MODE_BLEN_LSB    = 0;
	localparam int MODE_BTYPE_BIT   = 3;
	localparam int MODE_LAT_LSB     = 4;
	localparam int MODE_WSINGLE_BIT = 9;
	localparam int AUTO_PRE_BIT     = 10;
	localparam logic [2:0]  LAT_CODE_3     = 3'h3;
	localparam logic [2:0]  BLEN_CODE_1    = 3'h0;
	localparam logic [2:0]  BLEN_CODE_2    = 3'h1;
	localparam logic [2:0]  BLEN_CODE_4    = 3'h2;
	localparam logic [2:0]  BLEN_CODE_8    = 3'h3;
	localparam logic [2:0]  BLEN_CODE_FULL = 3'h7;
	localparam logic [11:0] MODE_RESET     = 12'h020;

	// ==========================================================
	// register map
	localparam logic [7:0] REG_STATUS  = 8'h00;
	localparam logic [7:0] REG_CTRL    = 8'h04;
	localparam logic [7:0] REG_REFCNT  = 8'h08;
	localparam int         CTRL_WP_BIT = 0;
	localparam logic       CTRL_WP_RESET = 1'h0;
	localparam logic [15:0] REFCNT_RESET = 16'h0000;

	// ==========================================================
	// types
	typedef enum logic [3:0] {
		CMD_NOP, CMD_MODE, CMD_REFRESH, CMD_SELF_ENTER, CMD_ACT,
		CMD_READ, CMD_WRITE, CMD_STOP, CMD_PRE
	} sdrct_cmd_e;

	typedef enum logic [1:0] {
		PWR_ACTIVE, PWR_DOWN, PWR_SELF
	} sdrct_pwr_e;

	typedef struct packed {
		logic              chip_select_n;
		logic              row_strobe_n;
		logic              column_strobe_n;
		logic              write_strobe_n;
		logic              bank_select_hi;
		logic              bank_select_lo;
		logic [ADDR_W-1:0] addr;
	} sdrct_pins_s;

	typedef struct packed {
		logic              self_refresh;
		logic              power_down;
		logic              burst_read;
		logic              burst_write;
		logic [NBANK-1:0]  bank_open;
		logic [ADDR_W-1:0] mode;
	} sdrct_status_s;

endpackage // sdrct_pkg

// [verilog/sdrct_burst_addr.sv]
// Purpose: column of the current beat of a burst
// Assumes: start column, beat count and length code held by the caller
// Notes:   full page wraps over all columns and never ends on its own

// ==========================================================
// burst address generator
module sdrct_burst_addr
	import sdrct_pkg::*;
(
	input  wire logic [COL_W-1:0] start_col,   // column latched with command
	input  wire logic [COL_W-1:0] beat,        // beat number in burst
	input  wire logic [2:0]       blen_code,   // burst length code
	input  wire logic             interleave,  // burst type select
	output logic      [COL_W-1:0] col,         // column of this beat
	output logic                  last         // this beat ends burst
);

	logic [COL_W-1:0] wrap_mask;
	logic             full_page;
	logic [COL_W-1:0] offset;

	// wrap boundary from length code; reserved codes act as one word
	always_comb begin
		full_page = (blen_code == BLEN_CODE_FULL);
		case (blen_code)
			BLEN_CODE_1:    wrap_mask = 8'h00;
			BLEN_CODE_2:    wrap_mask = 8'h01;
			BLEN_CODE_4:    wrap_mask = 8'h03;
			BLEN_CODE_8:    wrap_mask = 8'h07;
			BLEN_CODE_FULL: wrap_mask = 8'hff;
			default:        wrap_mask = 8'h00;
		endcase
		// order select
		// interleave only exists for short bursts, full page is sequential
		if (interleave && !full_page)
			offset = start_col ^ beat;
		else
			offset = 8'(start_col + beat);
		col = (start_col & ~wrap_mask) | (offset & wrap_mask);
		last = !full_page && (beat == wrap_mask);
	end

endmodule // sdrct_burst_addr

// [verilog/sdrct_apb_regs.sv]
// Purpose: apb slave with status, control and refresh counter
// Assumes: zero wait state, one access cycle per transfer
// Notes:   unmapped offsets answer with pslverr and zero data

// ==========================================================
// apb register file
module sdrct_apb_regs
	import sdrct_pkg::*;
(
	input  wire logic              pclk,          // bus clock
	input  wire logic              presetn,       // async reset, low
	input  wire logic              psel,          // slave select
	input  wire logic              penable,       // access phase
	input  wire logic              pwrite,        // write direction
	input  wire logic [APB_AW-1:0] paddr,         // byte address
	input  wire logic [31:0]       pwdata,        // write data
	output logic      [31:0]       prdata,        // read data
	output logic                   pready,        // transfer done
	output logic                   pslverr,       // unmapped address
	input  wire sdrct_status_s     status,        // core state
	input  wire logic              refresh_pulse, // one auto refresh
	output logic                   write_protect  // drop array writes
);

	logic [31:0] prdata_ff, nxt_prdata;
	logic        pready_ff, nxt_pready;
	logic        pslverr_ff, nxt_pslverr;
	logic        wp_ff, nxt_wp;
	logic [15:0] refcnt_ff, nxt_refcnt;
	logic        setup;
	logic        access;

	// decode in setup, answer in the single access cycle
	always_comb begin
		setup       = psel && !penable;
		access      = psel && penable && pready_ff;
		nxt_pready  = setup;
		nxt_prdata  = 32'h0000_0000;
		nxt_pslverr = 1'h0;
		nxt_wp      = wp_ff;
		nxt_refcnt  = refcnt_ff;
		if (refresh_pulse)
			nxt_refcnt = 16'(refcnt_ff + 16'h0001);
		if (setup) begin
			case (paddr)
				REG_STATUS: nxt_prdata = 32'(status);
				REG_CTRL:   nxt_prdata = 32'(wp_ff);
				REG_REFCNT: nxt_prdata = 32'(refcnt_ff);
				default:    nxt_pslverr = 1'h1;
			endcase
			if (pwrite)
				nxt_prdata = 32'h0000_0000;
		end
		// writes land only on the edge that completes the transfer
		if (access && pwrite && paddr == REG_CTRL)
			nxt_wp = pwdata[CTRL_WP_BIT];
	end

	// register stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= 32'h0000_0000;
			pready_ff  <= 1'h0;
			pslverr_ff <= 1'h0;
			wp_ff      <= CTRL_WP_RESET;
			refcnt_ff  <= REFCNT_RESET;
		end else begin
			prdata_ff  <= nxt_prdata;
			pready_ff  <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			wp_ff      <= nxt_wp;
			refcnt_ff  <= nxt_refcnt;
		end
	end

	assign prdata        = prdata_ff;
	assign pready        = pready_ff;
	assign pslverr       = pslverr_ff;
	assign write_protect = wp_ff;

endmodule // sdrct_apb_regs

// [verilog/sdrct_top.sv]
// Purpose: synchronous dram command, burst and data path core
// Assumes: pins synchronous to pclk; controller honours its spacings
// Notes:   array is a flop window indexed by bank, row and column bits
//
// The implementer's own choices: the APB register port and the register addresses.

// ==========================================================
// top
module sdrct_top
	import sdrct_pkg::*;
(
	input  wire logic              pclk,       // system clock
	input  wire logic              presetn,    // async reset, low
	input  wire logic              psel,       // apb select
	input  wire logic              penable,    // apb access phase
	input  wire logic              pwrite,     // apb write
	input  wire logic [APB_AW-1:0] paddr,      // apb byte address
	input  wire logic [31:0]       pwdata,     // apb write data
	output logic      [31:0]       prdata,     // apb read data
	output logic                   pready,     // apb ready
	output logic                   pslverr,    // apb error
	input  wire sdrct_pins_s       cmd_pins,   // select, strobes, address
	input  wire logic              clock_gate, // internal clock gate
	input  wire logic [LANES-1:0]  byte_mask,  // per byte mask
	input  wire logic [DATA_W-1:0] data_in,    // data pins, input side
	output logic      [DATA_W-1:0] data_out,   // data pins, output side
	output logic      [LANES-1:0]  data_oe     // per byte drive enable
);

	// ==========================================================
	// declarations
	sdrct_cmd_e           cmd;
	sdrct_pwr_e           pwr_ff, nxt_pwr;
	sdrct_status_s        status;
	logic                 cke_prev_ff, active, sel;
	logic [LANES-1:0]     mask_d1_ff;
	logic [1:0]           bank;
	logic [ADDR_W-1:0]    mode_ff, nxt_mode;
	logic                 lat3, interleave;
	logic [2:0]           rd_blen, wr_blen;
	logic                 burst_rd_ff, nxt_burst_rd;
	logic                 burst_wr_ff, nxt_burst_wr;
	logic [COL_W-1:0]     cnt_ff, nxt_cnt, start_ff, nxt_start, gcol;
	logic [1:0]           bbank_ff, nxt_bbank;
	logic [2:0]           blen_ff, nxt_blen;
	logic                 ap_ff, nxt_ap, glast;
	logic [NBANK-1:0]     close_req, bank_open;
	logic [ADDR_W-1:0]    bank_row [NBANK];
	logic [MEM_IDX_W-1:0] wr_idx, rd_idx;
	logic                 wr_go, write_protect;
	logic [LANES-1:0]     mem_we;
	logic [DATA_W-1:0]    rd_word;
	logic                 pipe_vld_ff, nxt_pipe_vld;
	logic [DATA_W-1:0]    pipe_data_ff, nxt_pipe_data;
	logic                 out_vld_ff, nxt_out_vld;
	logic [DATA_W-1:0]    data_out_ff, nxt_data_out;
	logic [LANES-1:0]     data_oe_ff, nxt_data_oe;

	// ==========================================================
	// command decode
	// deselect masks decode
	// gate and mask stay live while deselected; only decode is blocked
	always_comb begin
		active = cke_prev_ff;
		sel    = active && !cmd_pins.chip_select_n;
		bank   = {cmd_pins.bank_select_hi, cmd_pins.bank_select_lo};
		cmd    = CMD_NOP;
		if (sel) begin
			case ({cmd_pins.row_strobe_n, cmd_pins.column_strobe_n,
			       cmd_pins.write_strobe_n})
				3'h0:    cmd = CMD_MODE;
				3'h1:    cmd = clock_gate ? CMD_REFRESH : CMD_SELF_ENTER;
				3'h2:    cmd = CMD_PRE;
				3'h3:    cmd = CMD_ACT;
				3'h4:    cmd = CMD_WRITE;
				3'h5:    cmd = CMD_READ;
				3'h6:    cmd = CMD_STOP;
				default: cmd = CMD_NOP;
			endcase
		end
	end

	// ==========================================================
	// mode register and pin sampling
	// mode load latches options
	// reserved bits are stored as given and decoded nowhere
	always_comb begin
		nxt_mode   = (cmd == CMD_MODE) ? cmd_pins.addr : mode_ff;
		lat3       = (mode_ff[MODE_LAT_LSB +: 3] == LAT_CODE_3);
		interleave = mode_ff[MODE_BTYPE_BIT];
		rd_blen    = mode_ff[MODE_BLEN_LSB +: 3];
		wr_blen    = mode_ff[MODE_WSINGLE_BIT] ? BLEN_CODE_1 : rd_blen;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff     <= MODE_RESET;
			cke_prev_ff <= 1'h0;
			mask_d1_ff  <= 2'h0;
		end else begin
			mode_ff     <= nxt_mode;
			cke_prev_ff <= clock_gate;
			mask_d1_ff  <= byte_mask;
		end
	end

	// ==========================================================
	// burst engine
	sdrct_burst_addr u_burst_addr (
		.start_col  (start_ff),
		.beat       (cnt_ff),
		.blen_code  (blen_ff),
		.interleave (interleave),
		.col        (gcol),
		.last       (glast)
	);

	// a new column command overrides any burst in flight
	always_comb begin
		nxt_burst_rd = burst_rd_ff;
		nxt_burst_wr = burst_wr_ff;
		nxt_cnt      = cnt_ff;
		nxt_start    = start_ff;
		nxt_bbank    = bbank_ff;
		nxt_blen     = blen_ff;
		nxt_ap       = ap_ff;
		close_req    = 4'h0;
		if (active) begin
			if (burst_rd_ff || burst_wr_ff) begin
				if (glast) begin
					nxt_burst_rd = 1'h0;
					nxt_burst_wr = 1'h0;
					close_req[bbank_ff] = ap_ff;
				end else begin
					nxt_cnt = 8'(cnt_ff + 8'h01);
				end
			end
			case (cmd)
				CMD_READ, CMD_WRITE: begin
					nxt_start    = cmd_pins.addr[COL_W-1:0];
					nxt_bbank    = bank;
					nxt_ap       = cmd_pins.addr[AUTO_PRE_BIT];
					nxt_burst_rd = (cmd == CMD_READ);
					nxt_blen     = (cmd == CMD_READ) ? rd_blen : wr_blen;
					nxt_cnt      = (cmd == CMD_READ) ? 8'h00 : 8'h01;
					nxt_burst_wr = (cmd == CMD_WRITE) && (wr_blen != BLEN_CODE_1);
					if (cmd == CMD_WRITE && wr_blen == BLEN_CODE_1)
						close_req[bank] = cmd_pins.addr[AUTO_PRE_BIT];
				end
				CMD_STOP: begin
					nxt_burst_rd = 1'h0;
					nxt_burst_wr = 1'h0;
				end
				CMD_PRE: begin
					if (cmd_pins.addr[AUTO_PRE_BIT] || bank == bbank_ff) begin
						nxt_burst_rd = 1'h0;
						nxt_burst_wr = 1'h0;
					end
				end
				default: ;
			endcase
		end
	end

	// register stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			burst_rd_ff <= 1'h0;
			burst_wr_ff <= 1'h0;
			cnt_ff      <= 8'h00;
			start_ff    <= 8'h00;
			bbank_ff    <= 2'h0;
			blen_ff     <= BLEN_CODE_1;
			ap_ff       <= 1'h0;
		end else begin
			burst_rd_ff <= nxt_burst_rd;
			burst_wr_ff <= nxt_burst_wr;
			cnt_ff      <= nxt_cnt;
			start_ff    <= nxt_start;
			bbank_ff    <= nxt_bbank;
			blen_ff     <= nxt_blen;
			ap_ff       <= nxt_ap;
		end
	end

	// ==========================================================
	// bank rows
	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		logic              open_ff, nxt_open;
		logic [ADDR_W-1:0] row_ff, nxt_row;
		always_comb begin
			nxt_open = open_ff;
			nxt_row  = row_ff;
			if (cmd == CMD_ACT && bank == 2'(b)) begin
				nxt_open = 1'h1;
				nxt_row  = cmd_pins.addr;
			end else if (cmd == CMD_PRE &&
			             (cmd_pins.addr[AUTO_PRE_BIT] || bank == 2'(b))) begin
				nxt_open = 1'h0;
			end else if (close_req[b]) begin
				nxt_open = 1'h0;
			end
		end
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				open_ff <= 1'h0;
				row_ff  <= 12'h000;
			end else begin
				open_ff <= nxt_open;
				row_ff  <= nxt_row;
			end
		end
		assign bank_open[b] = open_ff;
		assign bank_row[b]  = row_ff;
	end

	// ==========================================================
	// storage window
	// only the low row and column bits address storage, so rows alias
	always_comb begin
		rd_idx = {bbank_ff, bank_row[bbank_ff][MEM_ROW_W-1:0],
		          gcol[MEM_COL_W-1:0]};
		wr_idx = rd_idx;
		if (cmd == CMD_WRITE)
			wr_idx = {bank, bank_row[bank][MEM_ROW_W-1:0],
			          cmd_pins.addr[MEM_COL_W-1:0]};
		wr_go = active && !write_protect && ((cmd == CMD_WRITE) ||
		        (burst_wr_ff && cmd != CMD_READ && cmd != CMD_STOP &&
		         cmd != CMD_PRE));
		mem_we = {LANES{wr_go}} & ~byte_mask;
	end

	for (genvar l = 0; l < LANES; l++) begin : g_lane
		logic [7:0] lane_ff [MEM_DEPTH];
		always_ff @(posedge pclk) begin
			if (mem_we[l])
				lane_ff[wr_idx] <= data_in[8*l +: 8];
		end
		assign rd_word[8*l +: 8] = lane_ff[rd_idx];
	end

	// ==========================================================
	// read data path
	// latency three adds one stage; gated cycles hold every stage
	always_comb begin
		nxt_pipe_vld  = pipe_vld_ff;
		nxt_pipe_data = pipe_data_ff;
		nxt_out_vld   = out_vld_ff;
		nxt_data_out  = data_out_ff;
		nxt_data_oe   = data_oe_ff;
		if (active) begin
			nxt_pipe_vld  = burst_rd_ff;
			nxt_pipe_data = rd_word;
			nxt_out_vld   = lat3 ? pipe_vld_ff : burst_rd_ff;
			nxt_data_out  = lat3 ? pipe_data_ff : rd_word;
			nxt_data_oe   = {LANES{nxt_out_vld}} & ~mask_d1_ff;
		end
	end

	// register stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pipe_vld_ff  <= 1'h0;
			pipe_data_ff <= 16'h0000;
			out_vld_ff   <= 1'h0;
			data_out_ff  <= 16'h0000;
			data_oe_ff   <= 2'h0;
		end else begin
			pipe_vld_ff  <= nxt_pipe_vld;
			pipe_data_ff <= nxt_pipe_data;
			out_vld_ff   <= nxt_out_vld;
			data_out_ff  <= nxt_data_out;
			data_oe_ff   <= nxt_data_oe;
		end
	end

	assign data_out = data_out_ff;
	assign data_oe  = data_oe_ff;

	// ==========================================================
	// power state
	// gate low enters low power when all banks are closed and no burst runs, or on self refresh entry
	always_comb begin
		nxt_pwr = pwr_ff;
		case (pwr_ff)
			PWR_ACTIVE: begin
				if (active && !clock_gate) begin
					if (cmd == CMD_SELF_ENTER)
						nxt_pwr = PWR_SELF;
					else if (bank_open == 4'h0 && !burst_rd_ff && !burst_wr_ff)
						nxt_pwr = PWR_DOWN;
				end
			end
			PWR_DOWN, PWR_SELF: begin
				if (clock_gate)
					nxt_pwr = PWR_ACTIVE;
			end
			default: nxt_pwr = PWR_ACTIVE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pwr_ff <= PWR_ACTIVE;
		else
			pwr_ff <= nxt_pwr;
	end

	// ==========================================================
	// register file
	always_comb begin
		status.self_refresh = (pwr_ff == PWR_SELF);
		status.power_down   = (pwr_ff == PWR_DOWN);
		status.burst_read   = burst_rd_ff;
		status.burst_write  = burst_wr_ff;
		status.bank_open    = bank_open;
		status.mode         = mode_ff;
	end

	sdrct_apb_regs u_regs (
		.pclk          (pclk),
		.presetn       (presetn),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.paddr         (paddr),
		.pwdata        (pwdata),
		.prdata        (prdata),
		.pready        (pready),
		.pslverr       (pslverr),
		.status        (status),
		.refresh_pulse (cmd == CMD_REFRESH),
		.write_protect (write_protect)
	);

	// ==========================================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_cs_ignore;
		active && cmd_pins.chip_select_n && !burst_rd_ff && !burst_wr_ff
		|=> $stable(bank_open) && $stable(mode_ff);
	endproperty
	a_cs_ignore: assert property (p_cs_ignore)
		else $error("deselected device changed state");

	property p_freeze;
		!cke_prev_ff |=> $stable(data_out_ff) && $stable(data_oe_ff)
		&& $stable(cnt_ff);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("gated cycle changed state");

	property p_act_row;
		cmd == CMD_ACT |=> bank_open[$past(bank)]
		&& bank_row[$past(bank)] == $past(cmd_pins.addr);
	endproperty
	a_act_row: assert property (p_act_row)
		else $error("activate did not latch row");

	property p_col_latch;
		cmd == CMD_READ |=> burst_rd_ff && cnt_ff == 8'h00
		&& start_ff == $past(cmd_pins.addr[COL_W-1:0]);
	endproperty
	a_col_latch: assert property (p_col_latch)
		else $error("read did not latch column");

	property p_mode;
		cmd == CMD_MODE |=> mode_ff == $past(cmd_pins.addr);
	endproperty
	a_mode: assert property (p_mode)
		else $error("mode load not stored");

	property p_lat2;
		cmd == CMD_READ && !lat3 ##1 cke_prev_ff |=> out_vld_ff;
	endproperty
	a_lat2: assert property (p_lat2)
		else $error("latency two data missing");

	property p_lat3;
		cmd == CMD_READ && lat3 ##1 cke_prev_ff && cmd != CMD_MODE
		##1 cke_prev_ff |=> out_vld_ff;
	endproperty
	a_lat3: assert property (p_lat3)
		else $error("latency three data missing");

	property p_rd_mask;
		byte_mask[0] && cke_prev_ff ##1 cke_prev_ff |=> !data_oe_ff[0];
	endproperty
	a_rd_mask: assert property (p_rd_mask)
		else $error("read mask latency wrong");

	property p_wr_mask;
		cmd == CMD_WRITE && byte_mask == 2'h3 |-> mem_we == 2'h0;
	endproperty
	a_wr_mask: assert property (p_wr_mask)
		else $error("masked write byte stored");

	property p_blen1;
		cmd == CMD_WRITE && wr_blen == BLEN_CODE_1 |=> !burst_wr_ff;
	endproperty
	a_blen1: assert property (p_blen1)
		else $error("single word write kept bursting");

	property p_stop3;
		cmd == CMD_STOP && lat3 && burst_rd_ff && pipe_vld_ff && clock_gate
		|-> ##1 out_vld_ff ##1 out_vld_ff;
	endproperty
	a_stop3: assert property (p_stop3)
		else $error("latency three stop drain wrong");

	property p_stop2;
		cmd == CMD_STOP && !lat3 && burst_rd_ff && clock_gate
		|-> ##1 out_vld_ff ##1 !out_vld_ff;
	endproperty
	a_stop2: assert property (p_stop2)
		else $error("latency two stop drain wrong");

	c_read3:  cover property (cmd == CMD_READ && lat3 ##3 out_vld_ff);
	c_wburst: cover property (burst_wr_ff [*3]);
	c_stop:   cover property (cmd == CMD_STOP && burst_rd_ff);
	c_self:   cover property (pwr_ff == PWR_SELF);

endmodule // sdrct_top

// [tb/sdrct_ctl_model.sv]
// Purpose: controller side model driving the sdram pins
// Assumes: one command launched per call, sampled next edge
// Notes:   released data lines show the inverse of the last value

// ==========================================================
// controller model
module sdrct_ctl_model
	import sdrct_pkg::*;
(
	input  wire logic         pclk,       // system clock
	output sdrct_pins_s       cmd_pins,   // select, strobes, address
	output logic              clock_gate, // internal clock gate
	output logic [LANES-1:0]  byte_mask,  // per byte mask
	output logic [DATA_W-1:0] data_drv    // data pins, driven side
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		clock_gate = 1'b1;
		cmd_pins = 18'h1_c000;
		byte_mask = 2'h0;
		data_drv = 16'h0000;
	end

	// twelve row lines, reserved zero
	// n high deselects the device for that one command
	task automatic issue(input logic [2:0] c, input logic [13:0] a,
		input logic [15:0] d, input logic [1:0] m, input logic n = 1'b0);
		@(posedge pclk);
		cmd_pins <= {n, c, a};
		byte_mask <= m;
		// an undriven bus must not keep its last value
		data_drv <= (d === 16'hxxxx) ? ~data_drv : d;
	endtask

	// gate moves alone
	// raised a full cycle before the next command reaches the pins
	task automatic gate(input logic g);
		@(posedge pclk);
		clock_gate <= g;
	endtask
endmodule // sdrct_ctl_model

// [tb/sdrct_top_test.sv]
// Purpose: self-checking bench for the sdram core
// Assumes: apb answers after one access cycle
// Notes:   one bank and row exercised per read latency

// ==========================================================
// bench top
module sdrct_top_test import sdrct_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
	logic        penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [1:0]  byte_mask, data_oe;
	logic [15:0] data_out, drv, dq, w0, w1;
	logic [11:0] mode;
	logic        clock_gate;
	sdrct_pins_s cmd_pins;
	int          mismatches = 0, tests_run = 0, cyc = 0, lat;

	always #50 pclk = ~pclk;
	// wire level: a lane the core drives wins
	assign dq = {data_oe[1] ? data_out[15:8] : drv[15:8],
		data_oe[0] ? data_out[7:0] : drv[7:0]};
	sdrct_top dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .cmd_pins, .clock_gate,
		.byte_mask, .data_in(dq), .data_out, .data_oe);
	sdrct_ctl_model ctl(.pclk, .cmd_pins, .clock_gate, .byte_mask,
		.data_drv(drv));

	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	// apb transfer, request held until pready is sampled
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wrap_up;
		$display("tests %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			wrap_up();
		end
	end

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, REG_STATUS, 32'h0000_0000);
		chk("status", rd, 32'h0000_0020);
		apb(1'b1, REG_CTRL, 32'h0000_0001);
		apb(1'b0, REG_CTRL, 32'h0000_0000);
		chk("ctrl", rd, 32'h0000_0001);
		apb(1'b1, REG_CTRL, 32'h0000_0000);
		// one 100 ns cycle covers minimums
		for (int i = 0; i < 2; i++) begin
			lat = i + 2;
			mode = (i == 0) ? 12'h021 : 12'h039;
			w0 = 16'h5a3c + 16'(i);
			w1 = 16'hc3a5 + 16'(i);
			ctl.issue(3'h2, 14'h0400, 16'hxxxx, 2'h0);
			ctl.issue(3'h1, 14'h0000, 16'hxxxx, 2'h0);
			ctl.issue(3'h0, {2'h0, mode}, 16'hxxxx, 2'h0);
			repeat (2) ctl.issue(3'h7, 14'h0000, 16'hxxxx, 2'h0);
			ctl.issue(3'h0, 14'h0000, 16'hxxxx, 2'h0, 1'b1);
			ctl.issue(3'h3, 14'h1005, 16'hxxxx, 2'h0);
			ctl.issue(3'h4, 14'h1000, w0, 2'h0);
			ctl.issue(3'h7, 14'h1000, w1, 2'h0);
			ctl.issue(3'h7, 14'h1000, 16'hxxxx, 2'h0);
			for (int k = -1; k < lat - 1; k++) begin
				ctl.issue(k < 0 ? 3'h5 : 3'h7, 14'h1000, 16'hxxxx,
					(k == lat - 3) ? 2'h1 : 2'h0);
			end
			repeat (2) @(negedge pclk);
			chk("mask_oe", data_oe, 2'h2);
			chk("beat0", data_out[15:8], w0[15:8]);
			@(negedge pclk);
			chk("beat1_oe", data_oe, 2'h3);
			chk("beat1", data_out, w1);
			@(negedge pclk);
			chk("end_oe", data_oe, 2'h0);
			ctl.issue(3'h5, 14'h1000, 16'hxxxx, 2'h0);
			ctl.issue(3'h6, 14'h1000, 16'hxxxx, 2'h0);
			ctl.issue(3'h7, 14'h1000, 16'hxxxx, 2'h0);
			repeat (lat - 1) @(negedge pclk);
			chk("stop_word", data_out, w0);
			chk("stop_oe", data_oe, 2'h3);
			@(negedge pclk);
			chk("stop_end", data_oe, 2'h0);
			apb(1'b0, REG_STATUS, 32'h0000_0000);
			chk("mode", rd[11:0], mode);
			apb(1'b0, REG_REFCNT, 32'h0000_0000);
			chk("refcnt", rd, 32'(i + 1));
			$display("test latency %0d done", lat);
		end
		ctl.issue(3'h2, 14'h0400, 16'hxxxx, 2'h0);
		ctl.issue(3'h7, 14'h0000, 16'hxxxx, 2'h0);
		ctl.gate(1'b0);
		apb(1'b0, REG_STATUS, 32'h0000_0000);
		chk("pwr_down", rd, 32'h0004_0000 | 32'(mode));
		ctl.gate(1'b1);
		apb(1'b0, REG_STATUS, 32'h0000_0000);
		chk("pwr_up", rd, 32'(mode));
		$display("test power down done");
		apb(1'b0, 8'h0c, 32'h0000_0000);
		chk("err", er, 1'b1);
		chk("err_data", rd, 32'h0000_0000);
		$display("test unmapped done");
		wrap_up();
	end
endmodule // sdrct_top_test
